// file: hw/mmap_decoder.sv
// Memory space decoder: flash, vectors, option bytes, RAM, peripheral area
//
// Overview of operation
// - 16-bit addresses, 64 KB, five region kinds
// - Flash from zero, 1/2/4 KB variants
// - Flash readable by fetch and data
// - Vector table at 0000H to 0013H
// - Vector low byte even, high odd
// - Fixed vector entry address per source
// - Table-call area 0040H to 007FH
// - 0080H decoded as configuration byte
// - 0081H decoded as protection byte
// - 128-byte RAM, stack usable
// - FF00H to FFFFH routed to peripherals
// - Short modes reach RAM window, peripherals
// - Reset loads counter from 0000H/0001H
`timescale 1ns/100ps
`include "mmap_params.svh"
module mmap_decoder #(
    parameter int FLASH_BYTES = `MMAP_FLASH_BYTES,
    parameter bit HAS_CONV    = 1'b1
) (
    // Clock and reset
    input  wire logic                     core_clk_i,
    input  wire logic                     reset_i,
    // CPU access
    input  wire mmap_pkg::mmap_req_t      req_i,
    output mmap_pkg::mmap_rsp_t           rsp_o,
    output mmap_pkg::mmap_region_t        region_o,
    // Vector lookup
    input  wire logic                     vec_req_i,
    input  wire mmap_pkg::mmap_vec_t      vec_sel_i,
    output logic                          vec_valid_o,
    output logic      [15:0]              vec_target_o,
    // Reset start address
    output logic                          boot_valid_o,
    output logic      [15:0]              program_counter_o,
    // Flash array port
    output logic                          flash_rd_o,
    output logic      [15:0]              flash_addr_o,
    input  wire logic [7:0]               flash_rdata_i,
    // Peripheral register bank
    output logic                          peri_we_o,
    output logic                          peri_re_o,
    output logic      [7:0]               peri_addr_o,
    output logic      [7:0]               peri_wdata_o,
    input  wire logic [7:0]               peri_rdata_i,
    // Option and protection bytes
    output logic                          cfg_sel_o,
    output logic                          prot_sel_o
);
    localparam int RAM_AW = $clog2(`MMAP_RAM_BYTES);

    initial begin
        if (FLASH_BYTES != 1024 && FLASH_BYTES != 2048 && FLASH_BYTES != 4096)
            $error("Flash size must be 1024, 2048 or 4096 bytes");
    end

    function automatic logic in_range(input logic [15:0] a, input logic [15:0] lo,
                                      input logic [15:0] hi);
        return (a >= lo) && (a <= hi);
    endfunction : in_range

    typedef enum logic [1:0] {
        ST_BOOT_LO = 2'b00,
        ST_BOOT_HI = 2'b01,
        ST_RUN     = 2'b10,
        ST_VEC_HI  = 2'b11
    } mmap_state_t;

    mmap_state_t state;
    mmap_state_t next_state;

    // Short modes expand to full address
    wire logic [15:0] eff_addr =
        (req_i.amode == mmap_pkg::AM_SADDR) ? {9'h1FD, req_i.addr[6:0]} :
        (req_i.amode == mmap_pkg::AM_SFR)   ? {8'hFF, req_i.addr[7:0]} :
        req_i.addr;

    wire logic [15:0] flash_last = 16'(FLASH_BYTES - 1);
    wire logic        hit_flash  = in_range(eff_addr, `MMAP_FLASH_BASE, flash_last);
    wire logic        hit_cfg    = (eff_addr == `MMAP_CFG_BYTE);
    wire logic        hit_prot   = (eff_addr == `MMAP_PROT_BYTE);
    wire logic        hit_ram    = in_range(eff_addr, `MMAP_RAM_BASE, `MMAP_RAM_LAST);
    wire logic        hit_peri   = in_range(eff_addr, `MMAP_PERI_BASE, `MMAP_PERI_LAST);
    wire logic        hit_vec    = in_range(eff_addr, `MMAP_VEC_BASE, `MMAP_VEC_LAST);
    wire logic        hit_tcall  = in_range(eff_addr, `MMAP_TCALL_BASE, `MMAP_TCALL_LAST);

    wire mmap_pkg::mmap_region_t cur_region =
        hit_cfg   ? mmap_pkg::REG_CFG   :
        hit_prot  ? mmap_pkg::REG_PROT  :
        hit_flash ? mmap_pkg::REG_FLASH :
        hit_ram   ? mmap_pkg::REG_RAM   :
        hit_peri  ? mmap_pkg::REG_PERI  : mmap_pkg::REG_NONE;

    // Vector entry address per source
    wire logic [15:0] vec_base =
        (vec_sel_i == mmap_pkg::VEC_RESET) ? `MMAP_VEC_RESET :
        (vec_sel_i == mmap_pkg::VEC_LVI)   ? `MMAP_VEC_LVI   :
        (vec_sel_i == mmap_pkg::VEC_EXTA)  ? `MMAP_VEC_EXTA  :
        (vec_sel_i == mmap_pkg::VEC_EXTB)  ? `MMAP_VEC_EXTB  :
        (vec_sel_i == mmap_pkg::VEC_TMH)   ? `MMAP_VEC_TMH   :
        (vec_sel_i == mmap_pkg::VEC_CMP0)  ? `MMAP_VEC_CMP0  :
        (vec_sel_i == mmap_pkg::VEC_CMP1)  ? `MMAP_VEC_CMP1  : `MMAP_VEC_CONV;
    wire logic vec_ok = (vec_sel_i != mmap_pkg::VEC_CONV) || HAS_CONV;

    wire logic run_idle  = (state == ST_RUN);
    wire logic data_go   = run_idle && req_i.valid && !vec_req_i;
    wire logic vec_go    = run_idle && vec_req_i && vec_ok;
    wire logic ram_we    = data_go && req_i.write && hit_ram;
    wire logic peri_we   = data_go && req_i.write && hit_peri;
    wire logic flash_rd  = (data_go && !req_i.write && hit_flash)
                           || vec_go || !run_idle;

    logic [15:0] vec_lo_addr;
    logic [7:0]  low_byte;
    logic        data_pend;
    logic        lo_pend;
    // High byte arrives one cycle after its address is driven
    logic        boot_hi_pend;
    logic        vec_hi_pend;

    wire logic [15:0] flash_addr =
        (state == ST_BOOT_LO) ? `MMAP_VEC_RESET :
        (state == ST_BOOT_HI) ? `MMAP_VEC_RESET + 16'h0001 :
        (state == ST_VEC_HI)  ? {vec_lo_addr[15:1], 1'b1} :
        vec_go ? vec_base : eff_addr;

    mmap_pkg::mmap_region_t pend_region;
    logic        pend_valid;
    logic [7:0]  ram_rdata;

    mmap_ram #(
        .DEPTH (`MMAP_RAM_BYTES)
    ) u_ram (
        .core_clk_i (core_clk_i),
        .we_i       (ram_we),
        .addr_i     (eff_addr[RAM_AW-1:0]),
        .wdata_i    (req_i.wdata),
        .rdata_o    (ram_rdata)
    );

    // Read data steering one cycle after the access
    wire logic [7:0] read_mux =
        (pend_region == mmap_pkg::REG_FLASH ||
         pend_region == mmap_pkg::REG_CFG ||
         pend_region == mmap_pkg::REG_PROT) ? flash_rdata_i :
        (pend_region == mmap_pkg::REG_RAM)  ? ram_rdata :
        (pend_region == mmap_pkg::REG_PERI) ? peri_rdata_i : `MMAP_OPEN_READ;

    always_comb begin
        next_state = state;
        unique case (state)
            ST_BOOT_LO: next_state = ST_BOOT_HI;
            ST_BOOT_HI: next_state = ST_RUN;
            ST_RUN:     next_state = vec_go ? ST_VEC_HI : ST_RUN;
            ST_VEC_HI:  next_state = ST_RUN;
        endcase
    end

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            state <= ST_BOOT_LO;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            data_pend   <= 1'b0;
            lo_pend     <= 1'b0;
            pend_valid  <= 1'b0;
            pend_region <= mmap_pkg::REG_NONE;
            vec_lo_addr <= 16'h0000;
            boot_hi_pend <= 1'b0;
            vec_hi_pend <= 1'b0;
        end else begin
            boot_hi_pend <= (state == ST_BOOT_HI);
            vec_hi_pend <= (state == ST_VEC_HI);
            data_pend   <= data_go;
            pend_valid  <= data_go && !req_i.write;
            pend_region <= cur_region;
            lo_pend     <= (state == ST_BOOT_LO) || vec_go;
            if (vec_go) begin
                vec_lo_addr <= vec_base;
            end
        end
    end

    // Low byte captured from the even address
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            low_byte <= 8'h00;
        end else if (lo_pend) begin
            low_byte <= flash_rdata_i;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            rsp_o             <= '0;
            region_o          <= mmap_pkg::REG_NONE;
            vec_valid_o       <= 1'b0;
            vec_target_o      <= 16'h0000;
            boot_valid_o      <= 1'b0;
            program_counter_o <= 16'h0000;
        end else begin
            rsp_o.valid <= data_pend;
            rsp_o.rdata <= pend_valid ? read_mux : 8'h00;
            region_o    <= cur_region;
            vec_valid_o <= 1'b0;
            if (vec_hi_pend) begin
                vec_valid_o  <= 1'b1;
                vec_target_o <= {flash_rdata_i, low_byte};
            end
            if (boot_hi_pend) begin
                boot_valid_o      <= 1'b1;
                program_counter_o <= {flash_rdata_i, low_byte};
            end
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            flash_rd_o   <= 1'b0;
            flash_addr_o <= 16'h0000;
            peri_we_o    <= 1'b0;
            peri_re_o    <= 1'b0;
            peri_addr_o  <= 8'h00;
            peri_wdata_o <= 8'h00;
            cfg_sel_o    <= 1'b0;
            prot_sel_o   <= 1'b0;
        end else begin
            flash_rd_o   <= flash_rd;
            flash_addr_o <= flash_addr;
            peri_we_o    <= peri_we;
            peri_re_o    <= data_go && !req_i.write && hit_peri;
            peri_addr_o  <= eff_addr[7:0];
            peri_wdata_o <= req_i.wdata;
            cfg_sel_o    <= data_go && hit_cfg;
            prot_sel_o   <= data_go && hit_prot;
        end
    end
endmodule : mmap_decoder

// file: hw/mmap_params.svh
// Address map constants for the memory space decoder
`ifndef MMAP_PARAMS_SVH
`define MMAP_PARAMS_SVH
`define MMAP_FLASH_BASE      16'h0000
`define MMAP_FLASH_BYTES     4096
`define MMAP_VEC_BASE        16'h0000
`define MMAP_VEC_LAST        16'h0013
`define MMAP_VEC_RESET       16'h0000
`define MMAP_VEC_LVI         16'h0006
`define MMAP_VEC_EXTA        16'h0008
`define MMAP_VEC_EXTB        16'h000A
`define MMAP_VEC_TMH         16'h000C
`define MMAP_VEC_CMP0        16'h000E
`define MMAP_VEC_CMP1        16'h0010
`define MMAP_VEC_CONV        16'h0012
`define MMAP_TCALL_BASE      16'h0040
`define MMAP_TCALL_LAST      16'h007F
`define MMAP_CFG_BYTE        16'h0080
`define MMAP_PROT_BYTE       16'h0081
`define MMAP_RAM_BASE        16'hFE80
`define MMAP_RAM_LAST        16'hFEFF
`define MMAP_RAM_BYTES       128
`define MMAP_PERI_BASE       16'hFF00
`define MMAP_PERI_LAST       16'hFFFF
`define MMAP_OPEN_READ       8'hFF
`endif

// file: hw/mmap_pkg.sv
// Types shared by the memory space decoder
package mmap_pkg;
    typedef enum logic [2:0] {
        REG_NONE  = 3'b000,
        REG_FLASH = 3'b001,
        REG_RAM   = 3'b010,
        REG_PERI  = 3'b011,
        REG_CFG   = 3'b100,
        REG_PROT  = 3'b101
    } mmap_region_t;

    typedef enum logic [1:0] {
        AM_FULL  = 2'b00,
        AM_SADDR = 2'b01,
        AM_SFR   = 2'b10
    } mmap_amode_t;

    typedef struct packed {
        logic        valid;
        logic        write;
        logic        fetch;
        mmap_amode_t amode;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } mmap_req_t;

    typedef struct packed {
        logic        valid;
        logic [7:0]  rdata;
    } mmap_rsp_t;

    typedef enum logic [2:0] {
        VEC_RESET = 3'b000,
        VEC_LVI   = 3'b001,
        VEC_EXTA  = 3'b010,
        VEC_EXTB  = 3'b011,
        VEC_TMH   = 3'b100,
        VEC_CMP0  = 3'b101,
        VEC_CMP1  = 3'b110,
        VEC_CONV  = 3'b111
    } mmap_vec_t;
endpackage : mmap_pkg

// file: hw/mmap_ram.sv
// Byte-wide on-chip high-speed RAM
`timescale 1ns/100ps
module mmap_ram #(
    parameter int DEPTH = 128
) (
    // Clock
    input  wire logic                     core_clk_i,
    // Access
    input  wire logic                     we_i,
    input  wire logic [$clog2(DEPTH)-1:0] addr_i,
    input  wire logic [7:0]               wdata_i,
    output logic      [7:0]               rdata_o
);
    logic [7:0] mem [DEPTH];

    initial begin
        if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
            $error("RAM depth must be a power of two");
    end

    always_ff @(posedge core_clk_i) begin
        if (we_i) begin
            mem[addr_i] <= wdata_i;
        end
        rdata_o <= mem[addr_i];
    end
endmodule : mmap_ram

// file: dv/mmap_decoder_chk.sv
// Port assertions for the memory space decoder
`timescale 1ns/100ps
module mmap_decoder_chk #(
    parameter int FLASH_BYTES = 4096,
    parameter bit HAS_CONV    = 1'b1
) (
    // Clock and reset
    input wire logic                   core_clk_i,
    input wire logic                   reset_i,
    // Watched ports
    input wire mmap_pkg::mmap_req_t    req_i,
    input wire mmap_pkg::mmap_rsp_t    rsp_o,
    input wire mmap_pkg::mmap_region_t region_o,
    input wire logic                   vec_req_i,
    input wire mmap_pkg::mmap_vec_t    vec_sel_i,
    input wire logic                   vec_valid_o,
    input wire logic                   boot_valid_o,
    input wire logic                   flash_rd_o,
    input wire logic [15:0]            flash_addr_o,
    input wire logic                   peri_we_o,
    input wire logic                   peri_re_o,
    input wire logic [7:0]             peri_addr_o,
    input wire logic [7:0]             peri_wdata_o,
    input wire logic                   cfg_sel_o,
    input wire logic                   prot_sel_o
);
    logic        vec_d1;
    wire  [15:0] a     = req_i.addr;
    wire  [7:0]  alo   = req_i.addr[7:0];
    wire  [7:0]  wd    = req_i.wdata;
    wire         full  = req_i.amode == mmap_pkg::AM_FULL;
    wire         vtake = vec_req_i && boot_valid_o && !vec_d1
                         && (HAS_CONV || vec_sel_i != mmap_pkg::VEC_CONV);
    wire         acc   = req_i.valid && !vec_req_i && !vec_d1 && boot_valid_o;
    wire  [15:0] ventry = (vec_sel_i == mmap_pkg::VEC_RESET) ? 16'h0000
                          : 16'h0004 + {12'h000, vec_sel_i, 1'b0};
    always_ff @(posedge core_clk_i) begin
        vec_d1 <= reset_i ? 1'b0 : vtake;
    end
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (reset_i);
    a_rsp_latency: assert property (acc |-> ##2 rsp_o.valid)
        else $error("missing response two cycles after an access");
    a_flash_route: assert property (acc && full && !req_i.write && a < FLASH_BYTES
        |=> flash_rd_o && flash_addr_o == $past(a)) else $error("flash read not routed");
    a_ram_local: assert property (acc && full && a inside {[16'hFE80:16'hFEFF]}
        |=> region_o == mmap_pkg::REG_RAM && !flash_rd_o && !peri_re_o && !peri_we_o)
        else $error("RAM access leaked");
    a_peri_write: assert property (acc && full && req_i.write && a >= 16'hFF00
        |=> peri_we_o && peri_addr_o == $past(alo) && peri_wdata_o == $past(wd))
        else $error("peripheral write not routed");
    a_sfr_short: assert property (acc && req_i.amode == mmap_pkg::AM_SFR && !req_i.write
        |=> peri_re_o && peri_addr_o == $past(alo)) else $error("short peripheral read lost");
    a_cfg_select: assert property (acc && full && a == 16'h0080
        |=> cfg_sel_o && !prot_sel_o) else $error("configuration byte not selected");
    a_prot_select: assert property (acc && full && a == 16'h0081
        |=> prot_sel_o && !cfg_sel_o) else $error("protection byte not selected");
    a_open_read: assert property (acc && full && !req_i.write && a >= FLASH_BYTES
        && a < 16'hFE80 |-> ##2 rsp_o.rdata == 8'hFF) else $error("unmapped read not FF");
    a_vec_fetch: assert property (vtake |=> flash_rd_o && flash_addr_o == $past(ventry)
        ##1 flash_addr_o == $past(ventry, 2) + 16'h0001 ##1 vec_valid_o)
        else $error("vector fetch sequence wrong");
    a_boot_fetch: assert property ($fell(reset_i) |=> flash_rd_o && flash_addr_o == 16'h0000
        ##1 flash_addr_o == 16'h0001) else $error("start fetch sequence wrong");
endmodule : mmap_decoder_chk
bind mmap_decoder mmap_decoder_chk #(.FLASH_BYTES(FLASH_BYTES), .HAS_CONV(HAS_CONV))
    mmap_decoder_chk_i (.core_clk_i, .reset_i, .req_i, .rsp_o, .region_o, .vec_req_i,
    .vec_sel_i, .vec_valid_o, .boot_valid_o, .flash_rd_o, .flash_addr_o, .peri_we_o,
    .peri_re_o, .peri_addr_o, .peri_wdata_o, .cfg_sel_o, .prot_sel_o);

// file: dv/mmap_far_model.sv
// Flash array and peripheral bank behind the decoder
`timescale 1ns/100ps
module mmap_far_model (
    // Clock
    input  wire logic        core_clk_i,
    // Flash array
    input  wire logic        flash_rd_i,
    input  wire logic [15:0] flash_addr_i,
    output logic      [7:0]  flash_rdata_o,
    // Peripheral bank
    input  wire logic        peri_we_i,
    input  wire logic        peri_re_i,
    input  wire logic [7:0]  peri_addr_i,
    input  wire logic [7:0]  peri_wdata_i,
    output logic      [7:0]  peri_rdata_o
);
    logic [7:0] bank [256];
    initial begin
        for (int i = 0; i < 256; i++) bank[i] = 8'(i) ^ 8'hC3;
    end
    // Data valid in the cycle of the strobe, inverted garbage otherwise
    assign flash_rdata_o = flash_rd_i ? (flash_addr_i[7:0] ^ flash_addr_i[15:8] ^ 8'h5A)
                                      : ~(flash_addr_i[7:0] ^ flash_addr_i[15:8] ^ 8'h5A);
    assign peri_rdata_o  = peri_re_i ? bank[peri_addr_i] : ~bank[peri_addr_i];
    always @(posedge core_clk_i) begin
        if (peri_we_i) bank[peri_addr_i] <= peri_wdata_i;
    end
endmodule : mmap_far_model

// file: dv/tb_memory_space_address_map.sv
// Self-checking bench for the memory space decoder
`timescale 1ns/100ps
module tb_memory_space_address_map;
    logic                core_clk_i;
    logic                reset_i;
    mmap_pkg::mmap_req_t req_i;
    mmap_pkg::mmap_rsp_t rsp_o;
    mmap_pkg::mmap_vec_t vec_sel_i;
    logic                vec_req_i, vec_valid_o, boot_valid_o, flash_rd_o, peri_we_o, peri_re_o;
    logic [15:0]         vec_target_o, program_counter_o, flash_addr_o, a;
    logic [7:0]          flash_rdata_i, peri_addr_o, peri_wdata_o, peri_rdata_i;
    logic [7:0]          dq[$], d[4];
    logic [6:0]          o[4];
    logic [15:0]         vq[$];
    logic [31:0]         r, seed = 32'h0000_CD33;
    int                  errors = 0, checks_done = 0, cycles = 0;
    logic [15:0]         ent[8] = '{16'h0000, 16'h0006, 16'h0008, 16'h000A,
                                    16'h000C, 16'h000E, 16'h0010, 16'h0012};
    mmap_decoder #(.FLASH_BYTES(4096), .HAS_CONV(1'b1)) mmap_decoder_i (
        .core_clk_i, .reset_i, .req_i, .rsp_o, .region_o(), .vec_req_i, .vec_sel_i,
        .vec_valid_o, .vec_target_o, .boot_valid_o, .program_counter_o, .flash_rd_o,
        .flash_addr_o, .flash_rdata_i, .peri_we_o, .peri_re_o, .peri_addr_o, .peri_wdata_o,
        .peri_rdata_i, .cfg_sel_o(), .prot_sel_o());
    mmap_far_model mmap_far_model_i (.core_clk_i, .flash_rd_i(flash_rd_o),
        .flash_addr_i(flash_addr_o), .flash_rdata_o(flash_rdata_i), .peri_we_i(peri_we_o),
        .peri_re_i(peri_re_o), .peri_addr_i(peri_addr_o), .peri_wdata_i(peri_wdata_o),
        .peri_rdata_o(peri_rdata_i));
    function automatic logic [7:0] fb(input logic [15:0] x);
        return x[7:0] ^ x[15:8] ^ 8'h5A;
    endfunction : fb
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic acc(input logic wr, input mmap_pkg::mmap_amode_t md, input logic [15:0] x,
                       input logic [7:0] wd, input logic [7:0] ex);
        req_i = '{1'b1, wr, r[20], md, x, wd};
        dq.push_back(wr ? 8'h00 : ex);
        @(posedge core_clk_i);
        #2;
    endtask : acc
    task automatic idle();
        req_i.valid = 1'b0;
        repeat (4) @(posedge core_clk_i);
        #2;
    endtask : idle
    task automatic stop_test();
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : stop_test
    initial begin
        core_clk_i = 1'b0;
        forever #12.5 core_clk_i = ~core_clk_i;
    end
    // Scoreboard: oldest note against each result
    always @(posedge core_clk_i) begin
        cycles++;
        if (rsp_o.valid === 1'b1) check("read data", rsp_o.rdata, dq.pop_front());
        if (vec_valid_o === 1'b1) check("vector", vec_target_o, vq.pop_front());
        if (cycles == 2000) begin
            errors++;
            stop_test();
        end
    end
    initial begin
        reset_i = 1'b1;
        req_i = '0;
        r = '0;
        vec_req_i = 1'b0;
        vec_sel_i = mmap_pkg::VEC_RESET;
        repeat (10) @(posedge core_clk_i);
        #2;
        reset_i = 1'b0;
        for (int i = 0; i < 20 && boot_valid_o !== 1'b1; i++) @(posedge core_clk_i);
        #2;
        check("start", program_counter_o, {fb(16'h0001), fb(16'h0000)});
        for (int s = 0; s < 8; s++) begin
            vec_req_i = 1'b1;
            vec_sel_i = mmap_pkg::mmap_vec_t'(s);
            vq.push_back({fb(ent[s] + 16'h0001), fb(ent[s])});
            @(posedge core_clk_i);
            #2;
            vec_req_i = 1'b0;
            repeat (4) @(posedge core_clk_i);
            #2;
        end
        for (int k = 0; k < 6; k++) begin
            r = rnd();
            a = {4'h0, r[11:0]};
            acc(1'b0, mmap_pkg::AM_FULL, a, 8'h00, fb(a));
        end
        a = 16'h0040 + {10'h000, r[5:0]};
        acc(1'b0, mmap_pkg::AM_FULL, a, 8'h00, fb(a));
        acc(1'b0, mmap_pkg::AM_FULL, 16'h0080, 8'h00, fb(16'h0080));
        acc(1'b0, mmap_pkg::AM_FULL, 16'h0081, 8'h00, fb(16'h0081));
        acc(1'b1, mmap_pkg::AM_FULL, 16'h0123, 8'hA5, 8'h00);
        acc(1'b1, mmap_pkg::AM_FULL, 16'h9000, 8'hA5, 8'h00);
        idle();
        acc(1'b0, mmap_pkg::AM_FULL, 16'h0123, 8'h00, fb(16'h0123));
        acc(1'b0, mmap_pkg::AM_FULL, 16'h9000, 8'h00, 8'hFF);
        acc(1'b0, mmap_pkg::AM_FULL, 16'hFFFF, 8'h00, 8'h3C);
        idle();
        for (int k = 0; k < 4; k++) begin
            r = rnd();
            o[k] = {k[1:0], r[4:0]};
            d[k] = r[15:8];
            acc(1'b1, mmap_pkg::AM_FULL, 16'hFE80 + {9'h000, o[k]}, d[k], 8'h00);
            acc(1'b1, mmap_pkg::AM_FULL, {9'h1FE, o[k]}, ~d[k], 8'h00);
        end
        idle();
        for (int k = 0; k < 4; k++) begin
            acc(1'b0, k[0] ? mmap_pkg::AM_SADDR : mmap_pkg::AM_FULL,
                k[0] ? {9'h000, o[k]} : 16'hFE80 + {9'h000, o[k]}, 8'h00, d[k]);
            acc(1'b0, mmap_pkg::AM_SFR, {9'h000, o[k]}, 8'h00, ~d[k]);
        end
        idle();
        stop_test();
    end
endmodule : tb_memory_space_address_map
